// ===== psa_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Visibility address is page register above data address bits 14..0
// - Word table read low returns program bits 15..0
// - Byte table read low picks upper byte when select is 1
// - Word table read high returns bits 23..16, upper data byte zero
// - Byte table read high returns bits 23..16 or zero for phantom byte
// - Program address steps by two per word
// - Table page bit 7 selects configuration space
// - Redirect only when address MSB set and window enabled
// - Visibility page picks one of 256 pages of 16K words
// - Visibility read costs up to two extra cycles, returns low 16 bits
// - Visibility suspended during table operations
// - Outside repeat: one extra cycle for moves, two for others
// - Inside repeat: two extra on edge iterations, none otherwise
// - Low ops touch bits 15..0, high ops bits 23..16
// - Table address is page register above effective address
// - Rows of 64 words, pages of eight rows, aligned from zero
// - Table writes touch only holding buffer, two cycles
// - Each row needs its own programming start
// - Go bit starts operation, hardware clears it when done
module psa_top #(
  parameter int BUF_DEPTH = psa_pkg::ROW_WORDS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // APB slave
  input wire logic [psa_pkg::APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core request port
  input wire logic coreReq,
  input wire psa_pkg::psa_op_e coreOp,
  input wire logic coreByte,
  input wire logic [15:0] coreEa,
  input wire logic [15:0] coreWrData,
  input wire logic coreIsMove,
  input wire logic coreInRepeat,
  input wire logic coreRepeatEdge,
  output logic coreReady,
  output logic coreDone,
  output logic [15:0] coreRdData,
  // Flash array
  output logic flashRdEn,
  output logic [23:0] flashAddr,
  input wire logic [23:0] flashRdData,
  output logic flashStart,
  output logic [23:0] flashOpAddr,
  output logic [3:0] flashOpSel,
  output logic flashErase,
  input wire logic flashOpDone,
  input wire logic [$clog2(BUF_DEPTH)-1:0] bufRdIdx,
  output logic [23:0] bufRdData
);
  localparam int IW = $clog2(BUF_DEPTH);

  psa_pkg::psa_state_e state_ff, nxt_state;
  logic [7:0] tblPage_ff, visPage_ff;
  logic constWin_ff, go_ff, nxt_go, wren_ff, wrerr_ff, erase_ff;
  logic [3:0] nvmOp_ff;
  logic [1:0] keyStage_ff;
  logic [23:0] progAddr_ff, wordCap_ff;
  psa_pkg::psa_op_e reqOp_ff;
  logic reqByte_ff, reqVis_ff, tblActive_ff;
  logic [15:0] reqEa_ff, reqWd_ff;
  logic [1:0] extra_ff, cnt_ff, extra;
  logic prdyFf, errFf;
  logic [31:0] rdFf;
  logic apbSetup, wr, nvmWr, startOp, badGo, vis, acc, isTwr;
  logic [31:0] rdMux;
  logic mapped;

  psa_buf_if #(.DEPTH(BUF_DEPTH), .LANES(3)) hb();

  psa_hold_buf #(.DEPTH(BUF_DEPTH), .LANES(3)) uHold (
    .mclk(mclk),
    .rst(rst),
    .bus(hb.store)
  );

  function automatic logic [15:0] mapRead(psa_pkg::psa_op_e op, logic bm, logic sel,
                                          logic [23:0] w);
    logic [15:0] r;
    r = 16'h0000;
    if (op == psa_pkg::OP_TRD_H) begin
      if (!bm || !sel) begin
        r = {8'h00, w[23:16]};
      end
    end else if (bm) begin
      r = {8'h00, sel ? w[15:8] : w[7:0]};
    end else begin
      r = w[15:0];
    end
    return r;
  endfunction

  // APB decode
  assign apbSetup = psel && !penable;
  assign wr = psel && penable && prdyFf && pwrite && !errFf;
  assign nvmWr = wr && (paddr == psa_pkg::OFS_NVM_CTRL) && !go_ff;
  assign startOp = nvmWr && pwdata[psa_pkg::NVM_GO_BIT] && pwdata[psa_pkg::NVM_WREN_BIT]
                   && (keyStage_ff == psa_pkg::KEY_ARMED);
  assign badGo = nvmWr && pwdata[psa_pkg::NVM_GO_BIT] && !startOp;

  always_comb begin
    mapped = 1'b1;
    rdMux = 32'h0000_0000;
    unique case (paddr)
      psa_pkg::OFS_TABLE_PAGE: rdMux = {24'h00_0000, tblPage_ff};
      psa_pkg::OFS_VIS_PAGE: rdMux = {24'h00_0000, visPage_ff};
      psa_pkg::OFS_CORE_CTRL: rdMux[psa_pkg::CORE_CONST_WIN_BIT] = constWin_ff;
      psa_pkg::OFS_NVM_CTRL: begin
        rdMux[psa_pkg::NVM_GO_BIT] = go_ff;
        rdMux[psa_pkg::NVM_WREN_BIT] = wren_ff;
        rdMux[psa_pkg::NVM_WRERR_BIT] = wrerr_ff;
        rdMux[psa_pkg::NVM_ERASE_BIT] = erase_ff;
        rdMux[3:0] = nvmOp_ff;
      end
      psa_pkg::OFS_NVM_KEY: rdMux = 32'h0000_0000;
      psa_pkg::OFS_STATUS: begin
        rdMux[psa_pkg::STATUS_BUSY_BIT] = go_ff;
        rdMux[psa_pkg::STATUS_ARMED_BIT] = (keyStage_ff == psa_pkg::KEY_ARMED);
        rdMux[psa_pkg::STATUS_TBL_BIT] = tblActive_ff;
      end
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      prdyFf <= 1'b0;
      errFf <= 1'b0;
      rdFf <= 32'h0000_0000;
    end else begin
      prdyFf <= apbSetup;
      errFf <= apbSetup && !mapped;
      if (apbSetup && !pwrite) begin
        rdFf <= rdMux;
      end
    end
  end

  // Software-owned setup registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      tblPage_ff <= psa_pkg::RST_PAGE;
      visPage_ff <= psa_pkg::RST_PAGE;
      constWin_ff <= 1'b0;
    end else if (wr) begin
      if (paddr == psa_pkg::OFS_TABLE_PAGE) begin
        tblPage_ff <= pwdata[7:0];
      end
      if (paddr == psa_pkg::OFS_VIS_PAGE) begin
        visPage_ff <= pwdata[7:0];
      end
      if (paddr == psa_pkg::OFS_CORE_CTRL) begin
        constWin_ff <= pwdata[psa_pkg::CORE_CONST_WIN_BIT];
      end
    end
  end

  // Unlock key: 55h then AAh on back-to-back writes, consumed by the next write
  always_ff @(posedge mclk) begin
    if (rst) begin
      keyStage_ff <= psa_pkg::KEY_IDLE;
    end else if (wr && paddr == psa_pkg::OFS_NVM_KEY) begin
      if (pwdata[7:0] == psa_pkg::KEY_FIRST) begin
        keyStage_ff <= psa_pkg::KEY_HALF;
      end else if (keyStage_ff == psa_pkg::KEY_HALF && pwdata[7:0] == psa_pkg::KEY_SECOND) begin
        keyStage_ff <= psa_pkg::KEY_ARMED;
      end else begin
        keyStage_ff <= psa_pkg::KEY_IDLE;
      end
    end else if (wr) begin
      keyStage_ff <= psa_pkg::KEY_IDLE;
    end
  end

  always_comb begin
    nxt_go = go_ff;
    if (startOp) begin
      nxt_go = 1'b1;
    end else if (flashOpDone) begin
      nxt_go = 1'b0;
    end
  end

  // Nonvolatile control; fields are frozen while an operation runs
  always_ff @(posedge mclk) begin
    if (rst) begin
      go_ff <= 1'b0;
      wren_ff <= 1'b0;
      wrerr_ff <= 1'b0;
      erase_ff <= 1'b0;
      nvmOp_ff <= psa_pkg::RST_NVM_OP;
      flashStart <= 1'b0;
      flashOpAddr <= 24'h00_0000;
      flashOpSel <= psa_pkg::RST_NVM_OP;
      flashErase <= 1'b0;
    end else begin
      go_ff <= nxt_go;
      flashStart <= startOp;
      if (nvmWr) begin
        wren_ff <= pwdata[psa_pkg::NVM_WREN_BIT];
        erase_ff <= pwdata[psa_pkg::NVM_ERASE_BIT];
        nvmOp_ff <= pwdata[3:0];
      end
      // Error set wins over a clearing write in the same cycle
      if (badGo) begin
        wrerr_ff <= 1'b1;
      end else if (nvmWr && !pwdata[psa_pkg::NVM_WRERR_BIT]) begin
        wrerr_ff <= 1'b0;
      end
      if (startOp) begin
        flashOpSel <= pwdata[3:0];
        flashErase <= pwdata[psa_pkg::NVM_ERASE_BIT];
        flashOpAddr <= progAddr_ff;
        if (pwdata[psa_pkg::NVM_ERASE_BIT]) begin
          flashOpAddr[psa_pkg::PAGE_ALIGN_BITS-1:0] <= '0;
        end else if (pwdata[3:0] == psa_pkg::NVM_OP_ROW) begin
          flashOpAddr[psa_pkg::ROW_ALIGN_BITS-1:0] <= '0;
        end
      end
    end
  end

  // Core request acceptance
  assign isTwr = (coreOp == psa_pkg::OP_TWT_L) || (coreOp == psa_pkg::OP_TWT_H);
  assign vis = (coreOp == psa_pkg::OP_DATA_RD) && coreEa[15] && constWin_ff
               && !tblActive_ff;
  assign acc = coreReq && coreReady && ((coreOp != psa_pkg::OP_DATA_RD) || vis);

  always_comb begin
    extra = psa_pkg::VIS_EXTRA_OTHER;
    if (!vis) begin
      extra = 2'h0;
    end else if (!coreInRepeat) begin
      extra = coreIsMove ? psa_pkg::VIS_EXTRA_MOVE : psa_pkg::VIS_EXTRA_OTHER;
    end else if (!coreRepeatEdge) begin
      extra = psa_pkg::VIS_EXTRA_RPT_MID;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      psa_pkg::ST_IDLE: begin
        if (acc) begin
          nxt_state = isTwr ? psa_pkg::ST_WBUF : psa_pkg::ST_FETCH;
        end
      end
      psa_pkg::ST_FETCH: nxt_state = psa_pkg::ST_CAPT;
      psa_pkg::ST_CAPT: nxt_state = (extra_ff == 2'h0) ? psa_pkg::ST_IDLE : psa_pkg::ST_WAIT;
      psa_pkg::ST_WAIT: begin
        if (cnt_ff == 2'h0) begin
          nxt_state = psa_pkg::ST_IDLE;
        end
      end
      psa_pkg::ST_WBUF: nxt_state = psa_pkg::ST_IDLE;
      default: nxt_state = psa_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff <= psa_pkg::ST_IDLE;
      coreReady <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      // Core stalls while an array operation runs
      coreReady <= (nxt_state == psa_pkg::ST_IDLE) && !nxt_go;
    end
  end

  // Request datapath
  always_ff @(posedge mclk) begin
    if (rst) begin
      reqOp_ff <= psa_pkg::OP_DATA_RD;
      reqByte_ff <= 1'b0;
      reqVis_ff <= 1'b0;
      reqEa_ff <= 16'h0000;
      reqWd_ff <= 16'h0000;
      extra_ff <= 2'h0;
      cnt_ff <= 2'h0;
      tblActive_ff <= 1'b0;
      wordCap_ff <= 24'h00_0000;
      progAddr_ff <= 24'h00_0000;
      flashRdEn <= 1'b0;
      flashAddr <= 24'h00_0000;
      coreDone <= 1'b0;
      coreRdData <= 16'h0000;
    end else begin
      flashRdEn <= 1'b0;
      coreDone <= 1'b0;
      unique case (state_ff)
        psa_pkg::ST_IDLE: begin
          if (acc) begin
            reqOp_ff <= coreOp;
            reqByte_ff <= coreByte;
            reqVis_ff <= vis;
            reqEa_ff <= coreEa;
            reqWd_ff <= coreWrData;
            extra_ff <= extra;
            tblActive_ff <= !vis;
            flashRdEn <= !isTwr;
            if (vis) begin
              flashAddr <= {1'b0, visPage_ff, coreEa[14:0]};
            end else begin
              flashAddr <= {tblPage_ff, coreEa};
            end
          end
        end
        psa_pkg::ST_FETCH: begin
        end
        psa_pkg::ST_CAPT: begin
          wordCap_ff <= flashRdData;
          cnt_ff <= extra_ff - 2'h1;
          if (extra_ff == 2'h0) begin
            coreDone <= 1'b1;
            tblActive_ff <= 1'b0;
            coreRdData <= mapRead(reqOp_ff, reqByte_ff, reqEa_ff[0], flashRdData);
          end
        end
        psa_pkg::ST_WAIT: begin
          cnt_ff <= cnt_ff - 2'h1;
          if (cnt_ff == 2'h0) begin
            coreDone <= 1'b1;
            coreRdData <= mapRead(reqOp_ff, reqByte_ff, reqEa_ff[0], wordCap_ff);
          end
        end
        psa_pkg::ST_WBUF: begin
          coreDone <= 1'b1;
          tblActive_ff <= 1'b0;
          progAddr_ff <= {tblPage_ff, reqEa_ff};
        end
        default: begin
        end
      endcase
    end
  end

  // Holding buffer write: word index from address bits 6..1
  assign hb.wrEn = (state_ff == psa_pkg::ST_WBUF);
  assign hb.wrIdx = reqEa_ff[IW:1];
  assign hb.rdIdx = bufRdIdx;
  always_comb begin
    if (reqOp_ff == psa_pkg::OP_TWT_H) begin
      hb.wrData = {reqWd_ff[7:0], 16'h0000};
      hb.wrLane = (!reqByte_ff || !reqEa_ff[0]) ? 3'h4 : 3'h0;
    end else begin
      hb.wrData = reqByte_ff ? {8'h00, reqWd_ff[7:0], reqWd_ff[7:0]} : {8'h00, reqWd_ff};
      hb.wrLane = !reqByte_ff ? 3'h3 : (reqEa_ff[0] ? 3'h2 : 3'h1);
    end
  end

  assign bufRdData = hb.rdData;
  assign prdata = rdFf;
  assign pready = prdyFf;
  assign pslverr = errFf;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_VIS_ADDR: assert property (acc && vis |=>
    flashAddr == {1'b0, $past(visPage_ff), $past(coreEa[14:0])})
    else $error("visibility address wrong");
  AST_TBL_ADDR: assert property (acc && !vis && !isTwr |=>
    flashRdEn && flashAddr == {$past(tblPage_ff), $past(coreEa)})
    else $error("table address wrong");
  AST_RDL_WORD: assert property (coreDone && reqOp_ff == psa_pkg::OP_TRD_L && !reqByte_ff
    |-> coreRdData == wordCap_ff[15:0])
    else $error("table read low word wrong");
  AST_RDH_PHANTOM: assert property (coreDone && reqOp_ff == psa_pkg::OP_TRD_H
    |-> coreRdData[15:8] == 8'h00)
    else $error("phantom byte not zero");
  AST_RDL_BYTE: assert property (coreDone && reqOp_ff == psa_pkg::OP_TRD_L && reqByte_ff
    |-> coreRdData == {8'h00, reqEa_ff[0] ? wordCap_ff[15:8] : wordCap_ff[7:0]})
    else $error("table read low byte wrong");
  AST_WIN_GATE: assert property (acc && coreOp == psa_pkg::OP_DATA_RD
    |-> coreEa[15] && constWin_ff)
    else $error("redirect without window");
  AST_STALL_MOVE: assert property (acc && vis && !coreInRepeat && coreIsMove
    |-> !coreDone[*4] ##1 coreDone)
    else $error("move stall not one cycle");
  AST_STALL_OTHER: assert property (acc && vis && !coreInRepeat && !coreIsMove
    |-> ##5 coreDone)
    else $error("other stall not two cycles");
  AST_RPT_MID: assert property (acc && vis && coreInRepeat && !coreRepeatEdge
    |-> ##3 coreDone)
    else $error("repeat iteration stalled");
  AST_TWR_TWO: assert property (acc && isTwr
    |=> !flashRdEn ##1 coreDone && !flashRdEn)
    else $error("table write not two cycles");
  AST_GO_START: assert property (flashStart
    |-> go_ff && $past(keyStage_ff) == psa_pkg::KEY_ARMED)
    else $error("start without unlock");
  AST_GO_CLEAR: assert property (go_ff && flashOpDone && !startOp |=> !go_ff)
    else $error("go bit not cleared");
  AST_ERASE_ALIGN: assert property (flashStart && flashErase
    |-> flashOpAddr[psa_pkg::PAGE_ALIGN_BITS-1:0] == '0)
    else $error("erase page misaligned");

  COV_VIS: cover property (acc && vis ##[3:5] coreDone);
  COV_TWR: cover property (acc && coreOp == psa_pkg::OP_TWT_H);
  COV_PROG: cover property (flashStart ##[1:100] !go_ff);
endmodule // psa_top

// ===== psa_pkg.sv
package psa_pkg;
  // APB map
  localparam int APB_AW = 8;
  localparam logic [7:0] OFS_TABLE_PAGE = 8'h00;
  localparam logic [7:0] OFS_VIS_PAGE = 8'h04;
  localparam logic [7:0] OFS_CORE_CTRL = 8'h08;
  localparam logic [7:0] OFS_NVM_CTRL = 8'h0C;
  localparam logic [7:0] OFS_NVM_KEY = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // Field positions
  localparam int CORE_CONST_WIN_BIT = 2;
  localparam int NVM_GO_BIT = 15;
  localparam int NVM_WREN_BIT = 14;
  localparam int NVM_WRERR_BIT = 13;
  localparam int NVM_ERASE_BIT = 6;
  localparam int TBL_CFG_BIT = 7;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_ARMED_BIT = 1;
  localparam int STATUS_TBL_BIT = 2;
  // Reset values
  localparam logic [7:0] RST_PAGE = 8'h00;
  localparam logic [3:0] RST_NVM_OP = 4'h0;
  // Unlock key
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [1:0] KEY_IDLE = 2'h0;
  localparam logic [1:0] KEY_HALF = 2'h1;
  localparam logic [1:0] KEY_ARMED = 2'h2;
  localparam logic [3:0] NVM_OP_ROW = 4'h1;
  // Array geometry: two address units per program word
  localparam int ROW_WORDS = 64;
  localparam int PAGE_ROWS = 8;
  localparam int ROW_ALIGN_BITS = $clog2(ROW_WORDS) + 1;
  localparam int PAGE_ALIGN_BITS = $clog2(ROW_WORDS * PAGE_ROWS) + 1;
  // Visibility stall cycles
  localparam logic [1:0] VIS_EXTRA_MOVE = 2'h1;
  localparam logic [1:0] VIS_EXTRA_OTHER = 2'h2;
  localparam logic [1:0] VIS_EXTRA_RPT_MID = 2'h0;

  typedef enum logic [2:0] {
    OP_DATA_RD = 3'h0,
    OP_TRD_L = 3'h1,
    OP_TRD_H = 3'h2,
    OP_TWT_L = 3'h3,
    OP_TWT_H = 3'h4
  } psa_op_e;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_FETCH = 5'h02,
    ST_CAPT = 5'h04,
    ST_WAIT = 5'h08,
    ST_WBUF = 5'h10
  } psa_state_e;
endpackage

// ===== psa_buf_if.sv
`timescale 1ns/1ps
interface psa_buf_if #(
  parameter int DEPTH = 64,
  parameter int LANES = 3
);
  logic wrEn;
  logic [$clog2(DEPTH)-1:0] wrIdx;
  logic [LANES-1:0] wrLane;
  logic [LANES*8-1:0] wrData;
  logic [$clog2(DEPTH)-1:0] rdIdx;
  logic [LANES*8-1:0] rdData;
  modport ctrl(output wrEn, wrIdx, wrLane, wrData, rdIdx, input rdData);
  modport store(input wrEn, wrIdx, wrLane, wrData, rdIdx, output rdData);
endinterface

// ===== psa_hold_buf.sv
`timescale 1ns/1ps
module psa_hold_buf #(
  parameter int DEPTH = 64,
  parameter int LANES = 3
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Holding buffer port
  psa_buf_if.store bus
);
  // One byte lane per generate block, so partial writes never collide
  for (genvar g = 0; g < LANES; g++) begin : gLane
    logic [7:0] lane [DEPTH];
    logic [7:0] rd_ff;
    always_ff @(posedge mclk) begin
      if (bus.wrEn && bus.wrLane[g]) begin
        lane[bus.wrIdx] <= bus.wrData[g*8 +: 8];
      end
    end
    always_ff @(posedge mclk) begin
      if (rst) begin
        rd_ff <= 8'h00;
      end else begin
        rd_ff <= lane[bus.rdIdx];
      end
    end
    assign bus.rdData[g*8 +: 8] = rd_ff;
  end
endmodule // psa_hold_buf

// ===== psa_flash_model.sv
`timescale 1ns/1ps
module psa_flash_model #(
  parameter int OP_CYCLES = 20
) (
  // Clock
  input wire logic mclk,
  // Read port
  input wire logic flashRdEn,
  input wire logic [23:0] flashAddr,
  output logic [23:0] flashRdData,
  // Operation port
  input wire logic flashStart,
  output logic flashOpDone
);
  logic [7:0] opCnt = 8'h00;

  initial begin
    flashRdData = 24'h00_0000;
    flashOpDone = 1'b0;
  end

  // Word valid one cycle after the fetch, scrambled once its hold runs out
  always @(posedge mclk) begin
    if (flashRdEn) begin
      flashRdData <= {flashAddr[23:16] ^ 8'h5A, {flashAddr[15:1], 1'b0} ^ 16'hC33C};
    end else begin
      flashRdData <= ~flashRdData;
    end
  end

  // Self-timed array operation ends with a done pulse
  always @(posedge mclk) begin
    flashOpDone <= (opCnt == 8'h01);
    if (flashStart) begin
      opCnt <= OP_CYCLES[7:0];
    end else if (opCnt != 8'h00) begin
      opCnt <= opCnt - 8'h01;
    end
  end
endmodule // psa_flash_model

// ===== tb_psa_top.sv
`timescale 1ns/1ps
module tb_psa_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic coreReq = 1'b0;
  psa_pkg::psa_op_e coreOp = psa_pkg::OP_DATA_RD;
  logic coreByte = 1'b0;
  logic [15:0] coreEa = 16'h0000;
  logic [15:0] coreWrData = 16'h0000;
  logic coreIsMove = 1'b0;
  logic coreInRepeat = 1'b0;
  logic coreRepeatEdge = 1'b0;
  logic coreReady;
  logic coreDone;
  logic [15:0] coreRdData;
  logic flashRdEn;
  logic [23:0] flashAddr;
  logic [23:0] flashRdData;
  logic flashStart;
  logic [23:0] flashOpAddr;
  logic [3:0] flashOpSel;
  logic flashErase;
  logic flashOpDone;
  logic [5:0] bufRdIdx = 6'h00;
  logic [23:0] bufRdData;
  logic [23:0] firstAddr = 24'h00_0000;
  logic gotRd = 1'b0;
  int errors = 0;
  int n_tests = 0;
  int starts = 0;

  always #25 mclk = ~mclk;

  psa_top psa_top_inst (.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .coreReq(coreReq), .coreOp(coreOp), .coreByte(coreByte), .coreEa(coreEa),
    .coreWrData(coreWrData), .coreIsMove(coreIsMove), .coreInRepeat(coreInRepeat),
    .coreRepeatEdge(coreRepeatEdge), .coreReady(coreReady), .coreDone(coreDone),
    .coreRdData(coreRdData), .flashRdEn(flashRdEn), .flashAddr(flashAddr),
    .flashRdData(flashRdData), .flashStart(flashStart), .flashOpAddr(flashOpAddr),
    .flashOpSel(flashOpSel), .flashErase(flashErase), .flashOpDone(flashOpDone),
    .bufRdIdx(bufRdIdx), .bufRdData(bufRdData));

  psa_flash_model #(.OP_CYCLES(20)) psa_flash_model_inst (.mclk(mclk), .flashRdEn(flashRdEn),
    .flashAddr(flashAddr), .flashRdData(flashRdData), .flashStart(flashStart),
    .flashOpDone(flashOpDone));

  // Registered outputs are looked at mid-cycle
  always @(negedge mclk) begin
    if (flashStart === 1'b1) starts++;
    if (flashRdEn === 1'b1 && !gotRd) begin
      firstAddr = flashAddr;
      gotRd = 1'b1;
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic results;
    if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Request stands until the edge that samples pready high; data taken there
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk("prdata", exp, r);
    chk("pslverr", {31'h0, experr}, {31'h0, e});
  endtask

  // Mode is {move, in repeat, repeat edge}; lat 0 means the request must go unanswered
  task automatic core(input psa_pkg::psa_op_e op, input logic by, input logic [15:0] ea,
    input logic [15:0] wd, input logic [2:0] mode, input int lat, input logic [15:0] exp,
    input logic [23:0] expAddr);
    int k;
    @(posedge mclk);
    coreReq <= 1'b1;
    coreOp <= op;
    coreByte <= by;
    coreEa <= ea;
    coreWrData <= wd;
    {coreIsMove, coreInRepeat, coreRepeatEdge} <= mode;
    gotRd = 1'b0;
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (coreReady !== 1'b1 && k < 50);
    @(posedge mclk);
    coreReq <= 1'b0;
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (coreDone !== 1'b1 && k < 12);
    if (lat == 0) begin
      chk("done", 32'h0000_0000, {31'h0, coreDone});
      chk("fetch", 32'h0000_0000, {31'h0, gotRd});
    end else begin
      chk("latency", lat, k);
      if (op == psa_pkg::OP_TRD_L || op == psa_pkg::OP_TRD_H || op == psa_pkg::OP_DATA_RD) begin
        chk("data", {16'h0000, exp}, {16'h0000, coreRdData});
        chk("addr", {8'h00, expAddr}, {8'h00, firstAddr & 24'hFF_FFFE});
      end
    end
  endtask

  task automatic t_regs;
    rd(psa_pkg::OFS_TABLE_PAGE, 32'h0000_0000, 1'b0);
    rd(psa_pkg::OFS_VIS_PAGE, 32'h0000_0000, 1'b0);
    rd(psa_pkg::OFS_CORE_CTRL, 32'h0000_0000, 1'b0);
    rd(psa_pkg::OFS_NVM_CTRL, 32'h0000_0000, 1'b0);
    wr(psa_pkg::OFS_NVM_KEY, 32'h0000_0033);
    rd(psa_pkg::OFS_NVM_KEY, 32'h0000_0000, 1'b0);
    wr(8'h18, 32'hFFFF_FFFF);
    rd(8'h18, 32'h0000_0000, 1'b1);
    wr(psa_pkg::OFS_TABLE_PAGE, 32'hFFFF_FFFF);
    rd(psa_pkg::OFS_TABLE_PAGE, 32'h0000_00FF, 1'b0);
  endtask

  task automatic t_table_rd;
    wr(psa_pkg::OFS_TABLE_PAGE, 32'h0000_0080);
    core(psa_pkg::OP_TRD_L, 1'b0, 16'h1234, 16'h0000, 3'h0, 3, 16'hD108, 24'h80_1234);
    core(psa_pkg::OP_TRD_L, 1'b1, 16'h1234, 16'h0000, 3'h0, 3, 16'h0008, 24'h80_1234);
    core(psa_pkg::OP_TRD_L, 1'b1, 16'h1235, 16'h0000, 3'h0, 3, 16'h00D1, 24'h80_1234);
    core(psa_pkg::OP_TRD_H, 1'b0, 16'h1234, 16'h0000, 3'h0, 3, 16'h00DA, 24'h80_1234);
    core(psa_pkg::OP_TRD_H, 1'b1, 16'h1234, 16'h0000, 3'h0, 3, 16'h00DA, 24'h80_1234);
    core(psa_pkg::OP_TRD_H, 1'b1, 16'h1235, 16'h0000, 3'h0, 3, 16'h0000, 24'h80_1234);
  endtask

  task automatic t_window;
    wr(psa_pkg::OFS_VIS_PAGE, 32'h0000_00B5);
    core(psa_pkg::OP_DATA_RD, 1'b0, 16'h8000, 16'h0000, 3'h0, 0, 16'h0000, 24'h00_0000);
    wr(psa_pkg::OFS_CORE_CTRL, 32'h0000_0004);
    core(psa_pkg::OP_DATA_RD, 1'b0, 16'h40F2, 16'h0000, 3'h0, 0, 16'h0000, 24'h00_0000);
    core(psa_pkg::OP_DATA_RD, 1'b0, 16'hC0F2, 16'h0000, 3'h4, 4, 16'h03CE, 24'h5A_C0F2);
    core(psa_pkg::OP_DATA_RD, 1'b0, 16'hC0F2, 16'h0000, 3'h0, 5, 16'h03CE, 24'h5A_C0F2);
    core(psa_pkg::OP_DATA_RD, 1'b0, 16'hC0F2, 16'h0000, 3'h3, 5, 16'h03CE, 24'h5A_C0F2);
    // Page bit 0 clear while address bit 15 set: bit 15 must follow the page
    wr(psa_pkg::OFS_VIS_PAGE, 32'h0000_00B4);
    core(psa_pkg::OP_DATA_RD, 1'b0, 16'hC0F2, 16'h0000, 3'h2, 3, 16'h83CE, 24'h5A_40F2);
  endtask

  task automatic t_program;
    logic [15:0] ea;
    logic [15:0] lo;
    logic [15:0] hi;
    wr(psa_pkg::OFS_TABLE_PAGE, 32'h0000_0000);
    // Whole aligned row of low and high writes; word 1 ends as 22_1111
    for (int i = 0; i < psa_pkg::ROW_WORDS; i++) begin
      ea = 16'h0700 + 16'(i * 2);
      lo = 16'h1110 + 16'(i);
      hi = 16'h0021 + 16'(i);
      core(psa_pkg::OP_TWT_L, 1'b0, ea, lo, 3'h0, 2, 16'h0000, 24'h00_0000);
      core(psa_pkg::OP_TWT_H, 1'b0, ea, hi, 3'h0, 2, 16'h0000, 24'h00_0000);
    end
    @(posedge mclk);
    bufRdIdx <= 6'h01;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk("buffer", 32'h0022_1111, {8'h00, bufRdData});
    core(psa_pkg::OP_TWT_L, 1'b1, 16'h0705, 16'h00AB, 3'h0, 2, 16'h0000, 24'h00_0000);
    core(psa_pkg::OP_TWT_H, 1'b1, 16'h0705, 16'h00CD, 3'h0, 2, 16'h0000, 24'h00_0000);
    @(posedge mclk);
    bufRdIdx <= 6'h02;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk("byte buffer", 32'h0023_AB12, {8'h00, bufRdData});
    wr(psa_pkg::OFS_NVM_KEY, 32'h0000_0055);
    wr(psa_pkg::OFS_NVM_KEY, 32'h0000_00AA);
    wr(psa_pkg::OFS_NVM_CTRL, 32'h0000_C001);
    // Start pulse and operation fields settle after the access edge
    repeat (2) @(negedge mclk);
    chk("starts", 1, starts);
    chk("row addr", 32'h0000_0700, {8'h00, flashOpAddr});
    chk("op sel", 32'h0000_0001, {28'h0, flashOpSel});
    chk("erase", 0, {31'h0, flashErase});
    chk("ready", 0, {31'h0, coreReady});
    rd(psa_pkg::OFS_STATUS, 32'h0000_0001, 1'b0);
    repeat (30) @(posedge mclk);
    rd(psa_pkg::OFS_NVM_CTRL, 32'h0000_4001, 1'b0);
    wr(psa_pkg::OFS_NVM_KEY, 32'h0000_0055);
    wr(psa_pkg::OFS_NVM_KEY, 32'h0000_00AA);
    wr(psa_pkg::OFS_NVM_CTRL, 32'h0000_C042);
    repeat (2) @(negedge mclk);
    chk("page addr", 32'h0000_0400, {8'h00, flashOpAddr});
    chk("op sel", 32'h0000_0002, {28'h0, flashOpSel});
    chk("erase", 1, {31'h0, flashErase});
    repeat (30) @(posedge mclk);
    wr(psa_pkg::OFS_NVM_CTRL, 32'h0000_C042);
    rd(psa_pkg::OFS_NVM_CTRL, 32'h0000_6042, 1'b0);
    chk("starts", 2, starts);
  endtask

  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_table_rd();
    t_window();
    t_program();
    results();
  end

  initial begin
    repeat (3000) @(posedge mclk);
    errors++;
    results();
  end
endmodule // tb_psa_top
